// ### rtl/asr_pkg.sv
package asr_pkg;
    localparam int RESULT_BITS = 16;
    localparam int BUSY_FRAME_FALLS = 17;
    localparam int PLAIN_FRAME_FALLS = 16;
    localparam int EDGE_CNT_W = 5;
    localparam int SYS_CLK_MHZ = 200;
    localparam int T_CONV_MIN_NS = 500;
    localparam int T_CONV_MAX_NS = 900;
    localparam int T_CONV_NS = 700;
    // Least time rounds up, longest rounds down
    localparam int CONV_MIN_CYC = (T_CONV_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CONV_MAX_CYC = (T_CONV_MAX_NS * SYS_CLK_MHZ) / 1000;
    localparam int CONV_CYC = (T_CONV_NS * SYS_CLK_MHZ) / 1000;
    localparam int CS_LOWER_CYC = 4;
    localparam int SCLK_HALF_CYC = 8;
    localparam int SCLK_HALF_MIN = 8;
    localparam int CNT_W = 12;

    typedef enum logic [1:0] {
        ASR_M3_BUSY = 2'h0,
        ASR_M4_PLAIN = 2'h1,
        ASR_M4_BUSY = 2'h2
    } asr_mode_t;

    typedef enum logic [1:0] {
        ASR_DEV_ACQ = 2'h0,
        ASR_DEV_CONV = 2'h1,
        ASR_DEV_WAIT_CS = 2'h2,
        ASR_DEV_SHIFT = 2'h3
    } asr_dev_state_t;

    typedef enum logic [2:0] {
        ASR_HST_IDLE = 3'h0,
        ASR_HST_CONV = 3'h1,
        ASR_HST_WAIT_IRQ = 3'h2,
        ASR_HST_READ = 3'h3,
        ASR_HST_FINISH = 3'h4
    } asr_hst_state_t;
endpackage

// ### rtl/asr_link_if.sv
interface asr_link_if;
    logic conversion_start_pin;
    logic din;
    logic sclk;
    logic dout_o;
    logic dout_oe;
    logic dout;

    // Pull-up on the data line keeps the host interrupt input high
    assign dout = dout_oe ? dout_o : 1'b1;

    modport dev (
        input conversion_start_pin,
        input din,
        input sclk,
        output dout_o,
        output dout_oe
    );

    modport host (
        output conversion_start_pin,
        output din,
        output sclk,
        input dout
    );
endinterface

// ### rtl/asr_device.sv
////////////////////////////////////////////////////////////////////////////////
module asr_device #(
    parameter int CONV_CYC = asr_pkg::CONV_CYC
) (
    // System
    input wire logic sys_clk,
    input wire logic rst,
    // Link pins
    asr_link_if.dev link,
    // Converter core
    input wire logic [asr_pkg::RESULT_BITS-1:0] sample_value,
    output logic converting,
    output logic powered_down,
    output logic chain_mode
);
    localparam int W = asr_pkg::EDGE_CNT_W;
    localparam int RB = asr_pkg::RESULT_BITS;
    localparam int CW = asr_pkg::CNT_W;

    generate
        if (CONV_CYC < asr_pkg::CONV_MIN_CYC ||
            CONV_CYC > asr_pkg::CONV_MAX_CYC ||
            CONV_CYC >= (1 << asr_pkg::CNT_W)) begin : g_bad_conv
            $error("CONV_CYC outside the conversion window");
        end
    endgenerate

    function automatic logic [W-1:0] gray_to_bin(input logic [W-1:0] g);
        logic [W-1:0] b;
        b[W-1] = g[W-1];
        for (int i = W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link clock domain: counts serial clock falling edges
    // The link clock may stand still, so its counter is cleared without it
    logic link_clr_reg;
    logic [W-1:0] fall_bin_reg;
    logic [W-1:0] fall_gray_reg;
    logic [W-1:0] fall_bin_next;

    always_ff @(posedge sys_clk) begin
        link_clr_reg <= rst;
    end

    assign fall_bin_next = fall_bin_reg + W'(1);

    always_ff @(negedge link.sclk or posedge link_clr_reg) begin
        if (link_clr_reg) begin
            fall_bin_reg <= '0;
            fall_gray_reg <= '0;
        end else begin
            fall_bin_reg <= fall_bin_next;
            fall_gray_reg <= fall_bin_next ^ (fall_bin_next >> 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the conversion clock
    logic [1:0] start_sync_reg;
    logic [1:0] din_sync_reg;
    logic start_prev_reg;
    logic din_prev_reg;
    logic [W-1:0] gray_s1_reg;
    logic [W-1:0] gray_s2_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            start_sync_reg <= 2'h0;
            din_sync_reg <= 2'h3;
            start_prev_reg <= 1'b0;
            din_prev_reg <= 1'b1;
            gray_s1_reg <= '0;
            gray_s2_reg <= '0;
        end else begin
            start_sync_reg <= {start_sync_reg[0], link.conversion_start_pin};
            din_sync_reg <= {din_sync_reg[0], link.din};
            start_prev_reg <= start_sync_reg[1];
            din_prev_reg <= din_sync_reg[1];
            gray_s1_reg <= fall_gray_reg;
            gray_s2_reg <= gray_s1_reg;
        end
    end

    logic start_s;
    logic din_s;
    logic start_rise;
    logic din_rise;
    logic din_fall;
    logic [W-1:0] falls_seen;

    assign start_s = start_sync_reg[1];
    assign din_s = din_sync_reg[1];
    assign start_rise = start_s & ~start_prev_reg;
    assign din_rise = din_s & ~din_prev_reg;
    assign din_fall = ~din_s & din_prev_reg;
    assign falls_seen = gray_to_bin(gray_s2_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Conversion and frame control
    asr_pkg::asr_dev_state_t state_reg;
    asr_pkg::asr_dev_state_t state_next;
    logic [asr_pkg::CNT_W-1:0] conv_cnt_reg;
    logic [RB-1:0] sample_reg;
    logic busy_frame_reg;
    logic three_wire_reg;
    logic chain_reg;
    logic [W-1:0] base_reg;
    logic conv_done;
    logic enter_shift;
    logic [W-1:0] edges;
    logic [W-1:0] frame_falls;
    logic frame_over;

    assign conv_done = (state_reg == asr_pkg::ASR_DEV_CONV) &&
        (conv_cnt_reg == CW'(CONV_CYC - 1));
    assign edges = falls_seen - base_reg;
    assign frame_falls = busy_frame_reg ? W'(asr_pkg::BUSY_FRAME_FALLS) :
        W'(asr_pkg::PLAIN_FRAME_FALLS);
    // Whichever comes first: the fall count, or the start pin rising in 3-wire mode and the select pin rising otherwise
    assign frame_over = (edges >= frame_falls) ||
        (three_wire_reg ? start_rise : din_rise);

    always_comb begin
        state_next = state_reg;
        if (start_rise && state_reg != asr_pkg::ASR_DEV_CONV) begin
            state_next = asr_pkg::ASR_DEV_CONV;
        end else begin
            unique case (state_reg)
                asr_pkg::ASR_DEV_ACQ: begin
                    state_next = asr_pkg::ASR_DEV_ACQ;
                end
                asr_pkg::ASR_DEV_CONV: begin
                    // Pin levels matter only at the end
                    if (conv_done) begin
                        if (chain_reg) begin
                            state_next = asr_pkg::ASR_DEV_ACQ;
                        end else if (!start_s || !din_s) begin
                            state_next = asr_pkg::ASR_DEV_SHIFT;
                        end else begin
                            state_next = asr_pkg::ASR_DEV_WAIT_CS;
                        end
                    end
                end
                asr_pkg::ASR_DEV_WAIT_CS: begin
                    if (din_fall) begin
                        state_next = asr_pkg::ASR_DEV_SHIFT;
                    end
                end
                asr_pkg::ASR_DEV_SHIFT: begin
                    if (frame_over) begin
                        state_next = asr_pkg::ASR_DEV_ACQ;
                    end
                end
            endcase
        end
    end

    assign enter_shift = (state_next == asr_pkg::ASR_DEV_SHIFT) &&
        (state_reg != asr_pkg::ASR_DEV_SHIFT);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= asr_pkg::ASR_DEV_ACQ;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conv_cnt_reg <= '0;
        end else if (state_next == asr_pkg::ASR_DEV_CONV &&
            state_reg != asr_pkg::ASR_DEV_CONV) begin
            conv_cnt_reg <= '0;
        end else if (state_reg == asr_pkg::ASR_DEV_CONV) begin
            conv_cnt_reg <= conv_cnt_reg + CW'(1);
        end
    end

    // Mode is chosen at the start edge; busy and wiring at the end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sample_reg <= '0;
            chain_reg <= 1'b0;
            busy_frame_reg <= 1'b0;
            three_wire_reg <= 1'b0;
        end else if (start_rise && state_reg != asr_pkg::ASR_DEV_CONV) begin
            // Core delivers two's complement codes as is
            sample_reg <= sample_value;
            chain_reg <= ~din_s;
        end else if (conv_done) begin
            busy_frame_reg <= ~start_s | ~din_s;
            three_wire_reg <= ~start_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            base_reg <= '0;
        end else if (enter_shift) begin
            base_reg <= falls_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data-out drive
    // Bit changes only after a falling edge has crossed over, so it stands
    // through the rising edge as long as the half period exceeds the latency
    logic dout_reg;
    logic dout_oe_reg;
    logic [W-1:0] bit_edges;
    logic [W-1:0] bit_pos;
    logic is_busy_slot;
    logic busy_now;

    // A frame opened by the select fall never carries a busy bit
    assign busy_now = enter_shift ?
        (~start_s | ~din_s) & (state_reg != asr_pkg::ASR_DEV_WAIT_CS) :
        busy_frame_reg;
    assign bit_edges = enter_shift ? '0 : edges;
    assign is_busy_slot = busy_now && bit_edges == '0;
    assign bit_pos = bit_edges - W'(busy_now);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dout_oe_reg <= 1'b0;
            dout_reg <= 1'b1;
        end else begin
            // Enabled only while a frame is open
            dout_oe_reg <= state_next == asr_pkg::ASR_DEV_SHIFT;
            if (is_busy_slot) begin
                dout_reg <= 1'b0;
            end else if (bit_pos < W'(RB)) begin
                dout_reg <= sample_reg[RB - 1 - int'(bit_pos)];
            end
        end
    end

    assign link.dout_o = dout_reg;
    assign link.dout_oe = dout_oe_reg;
    assign converting = state_reg == asr_pkg::ASR_DEV_CONV;
    assign powered_down = state_reg != asr_pkg::ASR_DEV_CONV;
    assign chain_mode = chain_reg;
endmodule

// ### rtl/asr_host.sv
module asr_host #(
    parameter int HALF_CYC = asr_pkg::SCLK_HALF_CYC,
    parameter int CONV_MAX = asr_pkg::CONV_MAX_CYC
) (
    // System
    input wire logic sys_clk,
    input wire logic rst,
    // Link pins
    asr_link_if.host link,
    // User request
    input wire logic start,
    input wire asr_pkg::asr_mode_t mode,
    output logic ready,
    // User result
    output logic [asr_pkg::RESULT_BITS-1:0] result,
    output logic result_valid
);
    localparam int CW = asr_pkg::CNT_W;

    generate
        if (HALF_CYC < asr_pkg::SCLK_HALF_MIN || CONV_MAX >= (1 << CW) ||
            asr_pkg::CS_LOWER_CYC >= asr_pkg::CONV_MIN_CYC) begin : g_bad
            $error("Host timing parameters out of range");
        end
    endgenerate

    asr_pkg::asr_hst_state_t state_reg;
    asr_pkg::asr_mode_t mode_reg;
    logic [CW-1:0] cnt_reg;
    logic [4:0] falls_reg;
    logic sclk_reg;
    logic start_pin_reg;
    logic din_reg;
    logic [1:0] dout_sync_reg;
    logic [asr_pkg::RESULT_BITS-1:0] shift_reg;
    logic [asr_pkg::RESULT_BITS-1:0] result_reg;
    logic valid_reg;
    logic busy_mode;
    logic half_done;
    logic [4:0] frame_falls;

    assign busy_mode = mode_reg != asr_pkg::ASR_M4_PLAIN;
    assign half_done = cnt_reg == CW'(HALF_CYC - 1);
    assign frame_falls = busy_mode ? 5'(asr_pkg::BUSY_FRAME_FALLS) :
        5'(asr_pkg::PLAIN_FRAME_FALLS);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dout_sync_reg <= 2'h3;
        end else begin
            dout_sync_reg <= {dout_sync_reg[0], link.dout};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= asr_pkg::ASR_HST_IDLE;
            mode_reg <= asr_pkg::ASR_M4_PLAIN;
            cnt_reg <= '0;
            falls_reg <= '0;
            sclk_reg <= 1'b1;
            start_pin_reg <= 1'b0;
            din_reg <= 1'b1;
            shift_reg <= '0;
        end else begin
            unique case (state_reg)
                asr_pkg::ASR_HST_IDLE: begin
                    cnt_reg <= '0;
                    falls_reg <= '0;
                    din_reg <= 1'b1;
                    start_pin_reg <= start;
                    if (start) begin
                        mode_reg <= mode;
                        state_reg <= asr_pkg::ASR_HST_CONV;
                    end
                end
                asr_pkg::ASR_HST_CONV: begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg == CW'(asr_pkg::CS_LOWER_CYC)) begin
                        if (mode_reg == asr_pkg::ASR_M3_BUSY) begin
                            start_pin_reg <= 1'b0;
                        end else if (mode_reg == asr_pkg::ASR_M4_BUSY) begin
                            din_reg <= 1'b0;
                        end
                    end
                    if (cnt_reg == CW'(CONV_MAX)) begin
                        cnt_reg <= '0;
                        if (busy_mode) begin
                            state_reg <= asr_pkg::ASR_HST_WAIT_IRQ;
                        end else begin
                            din_reg <= 1'b0;
                            state_reg <= asr_pkg::ASR_HST_READ;
                        end
                    end
                end
                asr_pkg::ASR_HST_WAIT_IRQ: begin
                    if (!dout_sync_reg[1]) begin
                        state_reg <= asr_pkg::ASR_HST_READ;
                    end
                end
                asr_pkg::ASR_HST_READ: begin
                    cnt_reg <= half_done ? '0 : cnt_reg + CW'(1);
                    if (half_done && sclk_reg) begin
                        // Sample just before the fall that moves the bit on
                        shift_reg <= {shift_reg[asr_pkg::RESULT_BITS-2:0],
                            dout_sync_reg[1]};
                        sclk_reg <= 1'b0;
                        falls_reg <= falls_reg + 5'(1);
                    end else if (half_done) begin
                        sclk_reg <= 1'b1;
                        if (falls_reg == frame_falls) begin
                            state_reg <= asr_pkg::ASR_HST_FINISH;
                        end
                    end
                end
                asr_pkg::ASR_HST_FINISH: begin
                    // Select released before start pin drops
                    din_reg <= 1'b1;
                    state_reg <= asr_pkg::ASR_HST_IDLE;
                end
                default: begin
                    state_reg <= asr_pkg::ASR_HST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= state_reg == asr_pkg::ASR_HST_FINISH;
            if (state_reg == asr_pkg::ASR_HST_FINISH) begin
                result_reg <= shift_reg;
            end
        end
    end

    // Start pin stays high through the read in 4-wire modes
    assign link.conversion_start_pin = start_pin_reg;
    assign link.din = din_reg;
    assign link.sclk = sclk_reg;
    assign ready = state_reg == asr_pkg::ASR_HST_IDLE;
    assign result = result_reg;
    assign result_valid = valid_reg;
endmodule

// ### sim/asr_asserts.sv
module asr_asserts #(
    parameter int CONV_CYC = 140
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link wires
    input wire logic conversion_start_pin,
    input wire logic din,
    input wire logic sclk,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic dout
);
    logic pin_q, sclk_q, oe_q;
    logic [8:0] rise_age;
    logic [8:0] din_age;
    logic [4:0] fall_cnt;
    asr_pkg::asr_mode_t kind;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        pin_q <= conversion_start_pin;
        sclk_q <= sclk;
        oe_q <= dout_oe;
    end

    // Saturates so an old start never looks like a fresh one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rise_age <= 9'h1FF;
        end else if (conversion_start_pin && !pin_q) begin
            rise_age <= 9'h001;
        end else if (rise_age != 9'h1FF) begin
            rise_age <= rise_age + 9'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || din) begin
            din_age <= 9'h000;
        end else if (din_age != 9'h1FF) begin
            din_age <= din_age + 9'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !dout_oe) begin
            fall_cnt <= 5'h00;
        end else if (!sclk && sclk_q) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    // A select that fell only just before the frame opened means plain mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            kind <= asr_pkg::ASR_M3_BUSY;
        end else if (dout_oe && !oe_q) begin
            if (!conversion_start_pin) begin
                kind <= asr_pkg::ASR_M3_BUSY;
            end else if (din_age < 9'h00A) begin
                kind <= asr_pkg::ASR_M4_PLAIN;
            end else begin
                kind <= asr_pkg::ASR_M4_BUSY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_start_off;
        $rose(conversion_start_pin) |-> ##[1:6] !dout_oe;
    endproperty
    a_start_off: assert property (p_start_off)
        else $error("line driven after conversion start");

    property p_conv_quiet;
        (rise_age >= 9'h008 && int'(rise_age) < CONV_CYC) |-> !dout_oe;
    endproperty
    a_conv_quiet: assert property (p_conv_quiet)
        else $error("line driven during conversion");

    property p_busy3_bit;
        $rose(dout_oe) && !conversion_start_pin |-> !dout_o;
    endproperty
    a_busy3_bit: assert property (p_busy3_bit)
        else $error("3-wire frame opened without low busy bit");

    property p_busy4_bit;
        $rose(dout_oe) && conversion_start_pin && din_age >= 9'h00A
            |-> !dout_o;
    endproperty
    a_busy4_bit: assert property (p_busy4_bit)
        else $error("4-wire frame opened without low busy bit");

    property p_plain_open;
        $fell(din) && conversion_start_pin && int'(rise_age) > CONV_CYC + 8
            |-> ##[1:6] dout_oe;
    endproperty
    a_plain_open: assert property (p_plain_open)
        else $error("select fall did not open the line");

    property p_bit_hold;
        $fell(sclk) && dout_oe |-> $stable(dout_o) [*3];
    endproperty
    a_bit_hold: assert property (p_bit_hold)
        else $error("data bit moved too close to a clock edge");

    property p_no_early;
        $fell(sclk) && dout_oe && fall_cnt < 5'h0E |-> ##6 dout_oe;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("frame closed early");

    property p_busy3_len;
        $fell(sclk) && dout_oe && kind == asr_pkg::ASR_M3_BUSY &&
            fall_cnt == 5'h10 |-> ##[1:8] !dout_oe;
    endproperty
    a_busy3_len: assert property (p_busy3_len)
        else $error("3-wire frame open after last fall");

    property p_plain_len;
        $fell(sclk) && dout_oe && kind == asr_pkg::ASR_M4_PLAIN &&
            fall_cnt == 5'h0F |-> ##[1:8] !dout_oe;
    endproperty
    a_plain_len: assert property (p_plain_len)
        else $error("plain frame open after last fall");

    property p_busy4_len;
        $fell(sclk) && dout_oe && kind == asr_pkg::ASR_M4_BUSY &&
            fall_cnt == 5'h10 |-> ##[1:8] !dout_oe;
    endproperty
    a_busy4_len: assert property (p_busy4_len)
        else $error("4-wire busy frame open after last fall");
endmodule

// ### sim/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, rst, start, ready, result_valid;
    asr_pkg::asr_mode_t mode;
    logic [15:0] value_a, value_b, result;
    logic conv_a, pd_a, chain_a, conv_b, pd_b, chain_b;
    logic sclk_q, last_bit;
    logic [16:0] cap;
    int falls, mismatches, comparisons;

    asr_link_if link();
    asr_link_if link2();

    asr_host asr_host_i (.sys_clk(sys_clk), .rst(rst), .link(link),
        .start(start), .mode(mode), .ready(ready), .result(result),
        .result_valid(result_valid));
    asr_device asr_device_i (.sys_clk(sys_clk), .rst(rst), .link(link),
        .sample_value(value_a), .converting(conv_a),
        .powered_down(pd_a), .chain_mode(chain_a));
    // Second device faces the bench so hosts faults can be made on purpose
    asr_device asr_device_i2 (.sys_clk(sys_clk), .rst(rst), .link(link2),
        .sample_value(value_b), .converting(conv_b),
        .powered_down(pd_b), .chain_mode(chain_b));
    asr_asserts #(.CONV_CYC(asr_pkg::CONV_CYC)) asr_asserts_i (
        .sys_clk(sys_clk), .rst(rst),
        .conversion_start_pin(link.conversion_start_pin), .din(link.din),
        .sclk(link.sclk), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
        .dout(link.dout));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Wire monitor: the bit seen just before each fall, as a host reads it
    always @(posedge sys_clk) begin
        sclk_q <= link.sclk;
        if (link.sclk) last_bit <= link.dout;
        if (!link.sclk && sclk_q && link.dout_oe) begin
            cap <= {cap[15:0], last_bit};
            falls <= falls + 1;
        end
    end

    task automatic chk(input logic [16:0] got, input logic [16:0] exp,
        input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait2(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Bench-made link clock, 6 ns, only while a frame is read
    task automatic sfalls(input int n);
        repeat (n) begin
            #3 link2.sclk = 1'b0;
            #3 link2.sclk = 1'b1;
        end
        #1.7;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic run_frame(input asr_pkg::asr_mode_t m,
        input logic [15:0] v);
        int n, f0;
        n = 0;
        f0 = falls;
        @(posedge sys_clk);
        mode <= m;
        value_a <= v;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        wait2(20);
        @(negedge sys_clk);
        chk({16'h0000, conv_a}, 17'h00001, "converting");
        while (result_valid !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        chk({16'h0000, result_valid}, 17'h00001, "done");
        chk({1'b0, result}, {1'b0, v}, "result");
        chk({16'h0000, pd_a}, 17'h00001, "power down");
        chk({16'h0000, chain_a}, 17'h00000, "chain");
        chk({1'b0, cap[15:0]}, {1'b0, v}, "wire bits");
        chk({15'h0000, link.dout_oe, link.dout}, 17'h00001, "released");
        if (m == asr_pkg::ASR_M4_PLAIN) begin
            chk(17'(falls - f0), 17'h00010, "falls");
        end else begin
            chk({16'h0000, cap[16]}, 17'h00000, "busy bit");
            chk(17'(falls - f0), 17'h00011, "falls");
        end
        $display("frame mode %0d done", m);
    endtask

    task automatic t_three_wire();
        run_frame(asr_pkg::ASR_M3_BUSY, 16'h8000);
    endtask

    task automatic t_four_plain();
        run_frame(asr_pkg::ASR_M4_PLAIN, 16'h7FFF);
    endtask

    task automatic t_four_busy();
        run_frame(asr_pkg::ASR_M4_BUSY, 16'hA5C3);
    endtask

    task automatic t_abort_three();
        @(posedge sys_clk);
        value_b <= 16'h8001;
        link2.conversion_start_pin <= 1'b1;
        wait2(4);
        link2.conversion_start_pin <= 1'b0;
        wait2(4);
        link2.conversion_start_pin <= 1'b1;
        wait2(4);
        link2.conversion_start_pin <= 1'b0;
        @(negedge sys_clk);
        chk({16'h0000, conv_b}, 17'h00001, "pin ignored");
        wait2(160);
        @(negedge sys_clk);
        chk({16'h0000, link2.dout}, 17'h00000, "busy low");
        sfalls(16);
        wait2(8);
        chk({16'h0000, link2.dout_oe}, 17'h00001, "16 falls");
        sfalls(1);
        wait2(8);
        chk({16'h0000, link2.dout_oe}, 17'h00000, "17 falls");
        link2.conversion_start_pin <= 1'b1;
        wait2(4);
        link2.conversion_start_pin <= 1'b0;
        wait2(160);
        sfalls(3);
        wait2(8);
        link2.conversion_start_pin <= 1'b1;
        wait2(8);
        chk({16'h0000, link2.dout}, 17'h00001, "pin closes");
        chk({16'h0000, conv_b}, 17'h00001, "new start");
        wait2(160);
        $display("three wire abort done");
    endtask

    task automatic t_abort_four();
        value_b <= 16'hC53A;
        link2.conversion_start_pin <= 1'b0;
        wait2(4);
        link2.conversion_start_pin <= 1'b1;
        wait2(4);
        link2.din <= 1'b0;
        wait2(4);
        link2.din <= 1'b1;
        @(negedge sys_clk);
        chk({16'h0000, conv_b}, 17'h00001, "din ignored");
        wait2(160);
        chk({16'h0000, link2.dout_oe}, 17'h00000, "no busy");
        link2.din <= 1'b0;
        wait2(8);
        chk({15'h0000, link2.dout_oe, link2.dout}, 17'h00003, "msb");
        sfalls(15);
        wait2(8);
        chk({16'h0000, link2.dout_oe}, 17'h00001, "15 falls");
        link2.din <= 1'b1;
        wait2(8);
        chk({16'h0000, link2.dout_oe}, 17'h00000, "din closes");
        chk({16'h0000, chain_b}, 17'h00000, "select");
        $display("four wire abort done");
    endtask

    task automatic t_chain();
        link2.conversion_start_pin <= 1'b0;
        link2.din <= 1'b0;
        wait2(4);
        link2.conversion_start_pin <= 1'b1;
        wait2(6);
        chk({16'h0000, chain_b}, 17'h00001, "chain");
        wait2(160);
        chk({16'h0000, link2.dout_oe}, 17'h00000, "chain idle");
        link2.din <= 1'b1;
        wait2(2);
        $display("chain select done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        start = 1'b0;
        mode = asr_pkg::ASR_M3_BUSY;
        value_a = 16'h0000;
        value_b = 16'h0000;
        link2.conversion_start_pin = 1'b0;
        link2.din = 1'b1;
        link2.sclk = 1'b1;
        wait2(5);
        rst <= 1'b0;
        t_three_wire();
        t_four_plain();
        t_four_busy();
        t_abort_three();
        t_abort_four();
        t_chain();
        summarize();
    end

    // Whole run needs well under 10k cycles
    initial begin
        wait2(40000);
        mismatches++;
        $display("FAIL t=%0t watchdog expired", $time);
        summarize();
    end
endmodule
